// ===== logic/cms_cfg.svh
// Constants of the controller mode sequencer
`ifndef CMS_CFG_SVH
`define CMS_CFG_SVH
`define CMS_ADDR_CTRL      12'h000
`define CMS_ADDR_STATUS    12'h004
`define CMS_ADDR_CMD       12'h008
`define CMS_ADDR_CFG       12'h00c
`define CMS_CTRL_START     0
`define CMS_CTRL_STOP      1
`define CMS_CTRL_CLEAR     2
`define CMS_CTRL_EXITHOLD  3
`define CMS_CTRL_COMM_RUN  4
`define CMS_CTRL_COMM_STOP 5
`define CMS_CTRL_RESTART   6
`define CMS_CFG_AUTO_HOT   0
`define CMS_CFG_HOT_ENABLE 1
`define CMS_CFG_RST        2'h0
`define CMS_CLEAR_CYCLES   4'h8
`endif

// ===== logic/cms_pkg.sv
// Types of the controller mode sequencer
package cms_pkg;
	typedef enum logic [2:0] {CMS_STOP, CMS_STARTUP, CMS_RUN, CMS_HOLD, CMS_DEFECT} cms_mode_t;
	typedef enum logic [1:0] {CMS_KEY_STOP, CMS_KEY_RUN, CMS_KEY_RUNP, CMS_KEY_CLEAR} cms_key_t;
	typedef enum logic [1:0] {CMS_WARM, CMS_HOT, CMS_COLD} cms_restart_t;
endpackage

// ===== logic/cms_sequencer.sv
// Operating mode sequencer with APB registers
`timescale 1ns/1ps
`include "cms_cfg.svh"
module cms_sequencer (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [1:0]  key_switch,
	input  wire logic        complete_restart_position,
	input  wire logic        power_up_event,
	input  wire logic        stopped_at_power_loss,
	input  wire logic        warm_aborted_at_power_loss,
	input  wire logic        startup_error,
	input  wire logic        startup_done,
	input  wire logic        program_stop,
	input  wire logic        breakpoint_hit,
	input  wire logic        error_unhandled,
	input  wire logic        download_in_stop,
	input  wire logic        stack_overflow,
	input  wire logic        hot_time_exceeded,
	input  wire logic        internal_fault,
	input  wire logic        flash_card_present,
	output cms_pkg::cms_mode_t mode,
	output logic [1:0]       startup_handler,
	output logic             program_run,
	output logic             outputs_substitute,
	output logic             outputs_disabled,
	output logic             timed_irq_block,
	output logic             timers_run,
	output logic             meters_run,
	output logic             clear_program,
	output logic             default_params,
	output logic             copy_from_card
);
	// Registered request pulses and settings
	logic [6:0] cmd;
	logic [1:0] cfg;
	logic       hold_from_startup;
	logic       warm_only;
	logic       clear_pending;
	logic [3:0] clear_cnt;
	logic       in_warm;
	cms_pkg::cms_mode_t next_mode;
	cms_pkg::cms_restart_t next_rtype;
	logic       key_run;
	logic       stop_req;
	logic       apb_wr;
	logic       start_req;
	logic       key_run_q;

	assign apb_wr = psel && penable && pwrite && pready;
	assign key_run = (key_switch == cms_pkg::CMS_KEY_RUN) || (key_switch == cms_pkg::CMS_KEY_RUNP);
	assign stop_req = (key_switch == cms_pkg::CMS_KEY_STOP) || cmd[`CMS_CTRL_STOP] || cmd[`CMS_CTRL_COMM_STOP];

	// Command register: each written bit is a one-cycle request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd <= 7'h00;
		end else if (apb_wr && paddr == `CMS_ADDR_CTRL && pstrb[0]) begin
			cmd <= pwdata[6:0];
		end else begin
			cmd <= 7'h00;
		end
	end

	// Configuration register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= `CMS_CFG_RST;
		end else if (apb_wr && paddr == `CMS_ADDR_CFG && pstrb[0]) begin
			cfg <= pwdata[1:0];
		end
	end

	// Previous key position; reset assumes run so a key already in run at power-on makes no false edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_run_q <= 1'b1;
		end else begin
			key_run_q <= key_run;
		end
	end

	// APB answers in the access cycle; zero wait states keep the master simple
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && (paddr != `CMS_ADDR_CTRL) && (paddr != `CMS_ADDR_STATUS)
				&& (paddr != `CMS_ADDR_CFG);
			prdata <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				if (paddr == `CMS_ADDR_STATUS) begin
					prdata <= {22'h000000, clear_pending, warm_only, hold_from_startup, startup_handler, 2'h0, mode};
				end else if (paddr == `CMS_ADDR_CFG) begin
					prdata <= {30'h00000000, cfg};
				end
			end
		end
	end

	// Start request from key, programmer, communication or power return, gated by key position
	always_comb begin
		start_req = 1'b0;
		if (key_run && !key_run_q)
			start_req = 1'b1;
		if (key_run && (cmd[`CMS_CTRL_START] || cmd[`CMS_CTRL_COMM_RUN]))
			start_req = 1'b1;
		if (key_run && power_up_event && !stopped_at_power_loss)
			start_req = 1'b1;
		if (key_run && power_up_event && warm_aborted_at_power_loss)
			start_req = 1'b1;
		if (key_run && cmd[`CMS_CTRL_RESTART])
			start_req = 1'b1;
	end

	// Next mode by fixed priority: defect, stop, hold, startup, run
	always_comb begin
		next_mode = mode;
		case (mode)
			cms_pkg::CMS_STOP: begin
				if (start_req && !clear_pending && !stop_req)
					next_mode = cms_pkg::CMS_STARTUP;
			end
			cms_pkg::CMS_STARTUP: begin
				if (startup_error || stop_req || program_stop)
					next_mode = cms_pkg::CMS_STOP;
				else if (breakpoint_hit)
					next_mode = cms_pkg::CMS_HOLD;
				else if (startup_done)
					next_mode = cms_pkg::CMS_RUN;
			end
			cms_pkg::CMS_RUN: begin
				if (error_unhandled || stop_req || program_stop)
					next_mode = cms_pkg::CMS_STOP;
				else if (breakpoint_hit)
					next_mode = cms_pkg::CMS_HOLD;
			end
			cms_pkg::CMS_HOLD: begin
				if (stop_req)
					next_mode = cms_pkg::CMS_STOP;
				else if (cmd[`CMS_CTRL_EXITHOLD])
					next_mode = hold_from_startup ? cms_pkg::CMS_STARTUP : cms_pkg::CMS_RUN;
			end
			cms_pkg::CMS_DEFECT: next_mode = cms_pkg::CMS_DEFECT;
			default: next_mode = cms_pkg::CMS_STOP;
		endcase
		if (internal_fault)
			next_mode = cms_pkg::CMS_DEFECT;
	end

	// Restart type chosen on entry to startup
	always_comb begin
		next_rtype = cms_pkg::CMS_WARM;
		if (power_up_event && warm_aborted_at_power_loss)
			next_rtype = cms_pkg::CMS_WARM;
		else if (warm_only)
			next_rtype = cms_pkg::CMS_WARM;
		else if (cmd[`CMS_CTRL_RESTART])
			next_rtype = cms_pkg::CMS_WARM;
		else if (power_up_event && cfg[`CMS_CFG_AUTO_HOT] && cfg[`CMS_CFG_HOT_ENABLE])
			next_rtype = cms_pkg::CMS_HOT;
		else if (!power_up_event && !complete_restart_position && cfg[`CMS_CFG_HOT_ENABLE])
			next_rtype = cms_pkg::CMS_HOT;
		else if (!power_up_event && !complete_restart_position)
			next_rtype = cms_pkg::CMS_COLD;
	end

	// Mode register; reset lands in stop before anything else
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= cms_pkg::CMS_STOP;
		end else begin
			mode <= next_mode;
		end
	end

	// Handler selection and origin of hold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			startup_handler <= 2'h0;
			hold_from_startup <= 1'b0;
			in_warm <= 1'b0;
		end else begin
			if (mode == cms_pkg::CMS_STOP && next_mode == cms_pkg::CMS_STARTUP) begin
				startup_handler <= next_rtype;
				in_warm <= (next_rtype == cms_pkg::CMS_WARM);
			end
			if (next_mode == cms_pkg::CMS_HOLD && mode != cms_pkg::CMS_HOLD)
				hold_from_startup <= (mode == cms_pkg::CMS_STARTUP);
		end
	end

	// Warm-only latch: set wins over the clear made by a completed warm start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			warm_only <= 1'b1;
		end else if (clear_cnt == 4'h1 || download_in_stop || stack_overflow || hot_time_exceeded
			|| (mode == cms_pkg::CMS_STARTUP && next_mode == cms_pkg::CMS_STOP && in_warm)) begin
			warm_only <= 1'b1;
		end else if (mode == cms_pkg::CMS_STARTUP && next_mode == cms_pkg::CMS_RUN && in_warm) begin
			warm_only <= 1'b0;
		end
	end

	// Memory reset: accepted only in stop, runs for a fixed count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clear_pending <= 1'b0;
			clear_cnt <= 4'h0;
		end else if (clear_cnt != 4'h0) begin
			clear_cnt <= clear_cnt - 4'h1;
			clear_pending <= (clear_cnt != 4'h1);
		end else if (mode == cms_pkg::CMS_STOP && next_mode == cms_pkg::CMS_STOP
			&& (key_switch == cms_pkg::CMS_KEY_CLEAR || cmd[`CMS_CTRL_CLEAR])) begin
			clear_pending <= 1'b1;
			clear_cnt <= `CMS_CLEAR_CYCLES;
		end
	end

	// Memory reset strobes; diagnostics, clock, meters and link settings untouched
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clear_program <= 1'b0;
			default_params <= 1'b0;
			copy_from_card <= 1'b0;
		end else begin
			clear_program <= clear_cnt == `CMS_CLEAR_CYCLES;
			default_params <= clear_cnt == `CMS_CLEAR_CYCLES;
			copy_from_card <= clear_cnt == 4'h2 && flash_card_present;
		end
	end

	// Execution controls per mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			program_run <= 1'b0;
			outputs_substitute <= 1'b1;
			outputs_disabled <= 1'b1;
			timed_irq_block <= 1'b1;
			timers_run <= 1'b0;
			meters_run <= 1'b0;
		end else begin
			program_run <= next_mode == cms_pkg::CMS_RUN;
			outputs_substitute <= next_mode == cms_pkg::CMS_STOP || next_mode == cms_pkg::CMS_DEFECT;
			outputs_disabled <= next_mode != cms_pkg::CMS_RUN;
			timed_irq_block <= next_mode != cms_pkg::CMS_RUN;
			timers_run <= next_mode == cms_pkg::CMS_STARTUP || next_mode == cms_pkg::CMS_RUN;
			meters_run <= next_mode == cms_pkg::CMS_STARTUP || next_mode == cms_pkg::CMS_RUN;
		end
	end

	// Checks
	stop_first_a: assert property (@(posedge pclk) $rose(presetn) |-> mode == cms_pkg::CMS_STOP)
		else $error("mode not stop after reset");
	stop_on_req_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode != cms_pkg::CMS_STOP && mode != cms_pkg::CMS_DEFECT && stop_req && !internal_fault)
		|=> mode == cms_pkg::CMS_STOP)
		else $error("stop request not obeyed");
	start_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == cms_pkg::CMS_STOP && !key_run) |=> mode != cms_pkg::CMS_STARTUP)
		else $error("startup without run position");
	bp_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == cms_pkg::CMS_RUN && breakpoint_hit && !stop_req && !error_unhandled && !program_stop
		&& !internal_fault) |=> mode == cms_pkg::CMS_HOLD)
		else $error("breakpoint did not hold");
	exit_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == cms_pkg::CMS_HOLD && hold_from_startup && cmd[`CMS_CTRL_EXITHOLD] && !stop_req
		&& !internal_fault) |=> mode == cms_pkg::CMS_STARTUP)
		else $error("exit hold wrong target");
	clear_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
		clear_pending |-> mode == cms_pkg::CMS_STOP || mode == cms_pkg::CMS_DEFECT)
		else $error("memory reset outside stop");
	subst_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode == cms_pkg::CMS_STOP |-> outputs_substitute && !program_run)
		else $error("outputs live in stop");
	defect_stays_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode == cms_pkg::CMS_DEFECT |=> mode == cms_pkg::CMS_DEFECT)
		else $error("left defective state");
	// Programmer start from stop
	stop_start_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == cms_pkg::CMS_STOP && key_run && cmd[`CMS_CTRL_START] && !clear_pending && !stop_req
		&& !internal_fault) |=> mode == cms_pkg::CMS_STARTUP)
		else $error("start command ignored");
	// Key moved into a run position starts from stop
	key_start_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == cms_pkg::CMS_STOP && key_run && !key_run_q && !clear_pending && !stop_req
		&& !internal_fault) |=> mode == cms_pkg::CMS_STARTUP)
		else $error("key move ignored");
	// Startup aborts to stop
	startup_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == cms_pkg::CMS_STARTUP && (startup_error || stop_req || program_stop) && !internal_fault)
		|=> mode == cms_pkg::CMS_STOP)
		else $error("startup not aborted");
	// Startup breakpoint holds
	startup_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == cms_pkg::CMS_STARTUP && breakpoint_hit && !startup_error && !stop_req && !program_stop
		&& !internal_fault) |=> mode == cms_pkg::CMS_HOLD)
		else $error("startup breakpoint ignored");
	// Stop from hold
	hold_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == cms_pkg::CMS_HOLD && stop_req && !internal_fault) |=> mode == cms_pkg::CMS_STOP)
		else $error("hold not stopped");
	// Successful startup reaches run
	startup_run_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == cms_pkg::CMS_STARTUP && startup_done && !startup_error && !stop_req && !program_stop
		&& !breakpoint_hit && !internal_fault) |=> mode == cms_pkg::CMS_RUN)
		else $error("startup did not complete");
	// Run stops on its causes
	run_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == cms_pkg::CMS_RUN && (error_unhandled || stop_req || program_stop) && !internal_fault)
		|=> mode == cms_pkg::CMS_STOP)
		else $error("run not stopped");
	// Hold halts the program and keeps outputs off
	hold_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode == cms_pkg::CMS_HOLD |-> !program_run && outputs_disabled)
		else $error("program runs in hold");
	// Exit from a user breakpoint goes back to run
	exit_run_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == cms_pkg::CMS_HOLD && !hold_from_startup && cmd[`CMS_CTRL_EXITHOLD] && !stop_req
		&& !internal_fault) |=> mode == cms_pkg::CMS_RUN)
		else $error("exit hold not to run");
	// Run executes with live outputs
	run_outputs_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode == cms_pkg::CMS_RUN |-> program_run && !outputs_substitute && !outputs_disabled)
		else $error("outputs dead in run");
	// No memory reset begins outside stop
	clear_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!clear_pending && mode != cms_pkg::CMS_STOP) |=> !clear_pending)
		else $error("memory reset began outside stop");
	// Clear and default strobes follow the start of a memory reset
	clear_strobe_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(clear_pending) |=> clear_program && default_params)
		else $error("memory reset strobes missing");
	// Startup keeps timed execution blocked while timers and meters run
	startup_ctrl_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode == cms_pkg::CMS_STARTUP |-> timed_irq_block && outputs_disabled && timers_run && meters_run)
		else $error("startup controls wrong");
	// A finished memory reset leaves only warm restart
	clear_warm_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(clear_pending) |-> warm_only)
		else $error("warm only not set by memory reset");
	// Warm only forces the warm handler
	warm_forced_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == cms_pkg::CMS_STOP && warm_only) ##1 mode == cms_pkg::CMS_STARTUP |-> startup_handler == 2'h0)
		else $error("restart not warm");
	// Manual warm restart command
	manual_warm_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == cms_pkg::CMS_STOP && key_run && cmd[`CMS_CTRL_RESTART] && !clear_pending && !stop_req
		&& !internal_fault) |=> mode == cms_pkg::CMS_STARTUP && startup_handler == 2'h0)
		else $error("manual warm restart wrong");
	// Power return starts when not stopped at power loss
	power_start_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == cms_pkg::CMS_STOP && key_run && power_up_event && !stopped_at_power_loss && !clear_pending
		&& !stop_req && !internal_fault) |=> mode == cms_pkg::CMS_STARTUP)
		else $error("no start on power return");
	// An interrupted warm restart resumes warm whatever is configured
	aborted_warm_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == cms_pkg::CMS_STOP && key_run && power_up_event && warm_aborted_at_power_loss
		&& !clear_pending && !stop_req && !internal_fault)
		|=> mode == cms_pkg::CMS_STARTUP && startup_handler == 2'h0)
		else $error("aborted warm not resumed warm");
	// Fault always wins
	defect_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
		internal_fault |=> mode == cms_pkg::CMS_DEFECT)
		else $error("fault not taken");
	run_cov: cover property (@(posedge pclk) disable iff (!presetn)
		mode == cms_pkg::CMS_STARTUP ##1 mode == cms_pkg::CMS_RUN);
	hold_cov: cover property (@(posedge pclk) disable iff (!presetn)
		mode == cms_pkg::CMS_HOLD ##1 mode == cms_pkg::CMS_RUN);
	clear_cov: cover property (@(posedge pclk) disable iff (!presetn) $rose(clear_pending));
	// Hold left back into startup, and the defective state reached
	hold_start_cov: cover property (@(posedge pclk) disable iff (!presetn)
		mode == cms_pkg::CMS_HOLD ##1 mode == cms_pkg::CMS_STARTUP);
	defect_cov: cover property (@(posedge pclk) disable iff (!presetn) mode == cms_pkg::CMS_DEFECT);
endmodule

// ===== tb/cms_prog_model.sv
// Programming device, key switch and communication function model
`timescale 1ns/1ps
module cms_prog_model (
	input  wire logic        pclk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	output logic [3:0]       pstrb,
	output logic [1:0]       key_switch,
	output logic             complete_restart_position
);
	// Idle bus and key in stop from time zero
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hf;
		key_switch = 2'h0;
		complete_restart_position = 1'b1;
	end
	// Key moves land just after an edge; the bench turns the key to clear only in stop
	task set_key(input logic [1:0] k);
		@(posedge pclk) key_switch <= k;
	endtask
	// Restart-type switch moves just after an edge
	task set_restart(input logic v);
		@(posedge pclk) complete_restart_position <= v;
	endtask
	// One APB transfer, held until pready is sampled high
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d; // Released data must not look still valid
	endtask
endmodule

// ===== tb/cms_sequencer_tb_top.sv
// Self-checking bench for the controller mode sequencer
`timescale 1ns/1ps
`include "cms_cfg.svh"
module cms_sequencer_tb_top;
	logic pclk = 1'b0, presetn = 1'b0, power_up_event = 1'b0, stopped_at_power_loss = 1'b0;
	logic warm_aborted_at_power_loss = 1'b0, stack_overflow = 1'b0, hot_time_exceeded = 1'b0;
	logic flash_card_present = 1'b1;
	logic [6:0] ev = 7'h0; // Fault, download, unhandled, breakpoint, stop, done, error
	logic psel, penable, pwrite, pready, pslverr, complete_restart_position, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0] pstrb;
	logic [1:0] key_switch, startup_handler;
	cms_pkg::cms_mode_t mode;
	logic program_run, outputs_substitute, outputs_disabled, timed_irq_block, timers_run, meters_run;
	logic clear_program, default_params, copy_from_card;
	int mismatches = 0, n_tests = 0, n_clr = 0, n_cp = 0;

	cms_sequencer cms_sequencer_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .key_switch, .complete_restart_position, .power_up_event, .stopped_at_power_loss,
		.warm_aborted_at_power_loss, .startup_error(ev[0]), .startup_done(ev[1]), .program_stop(ev[2]),
		.breakpoint_hit(ev[3]), .error_unhandled(ev[4]), .download_in_stop(ev[5]), .stack_overflow,
		.hot_time_exceeded, .internal_fault(ev[6]), .flash_card_present, .mode, .startup_handler, .program_run,
		.outputs_substitute, .outputs_disabled, .timed_irq_block, .timers_run, .meters_run, .clear_program,
		.default_params, .copy_from_card);
	cms_prog_model cms_prog_model_inst (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .key_switch, .complete_restart_position);

	always #20 pclk = ~pclk;
	// Clear pulses stand one cycle only, so they are counted as they pass
	always @(posedge pclk) begin
		n_clr <= n_clr + int'((clear_program & default_params) === 1'b1);
		n_cp <= n_cp + int'(copy_from_card === 1'b1);
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task test_done;
		$display("checks=%0d mismatches=%0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Bounded wait, since the mode answer is one or two edges after its cause
	task wait_mode(input cms_pkg::cms_mode_t m);
		for (int i = 0; i < 8 && mode !== m; i++)
			@(posedge pclk) #1;
		chk(32'(mode), 32'(m));
	endtask
	task pulse(input logic [6:0] m);
		@(posedge pclk) ev <= m;
		@(posedge pclk) ev <= 7'h0;
	endtask
	task ctrl(input logic [31:0] d);
		cms_prog_model_inst.xfer(1'b1, `CMS_ADDR_CTRL, d, q, e);
	endtask
	task key(input logic [1:0] k);
		cms_prog_model_inst.set_key(k);
	endtask
	task enter_run;
		key(2'h1);
		wait_mode(cms_pkg::CMS_STARTUP);
		pulse(7'h02);
		wait_mode(cms_pkg::CMS_RUN);
	endtask

	// Power-on state, register defaults and a refused address
	task t_reset;
		wait_mode(cms_pkg::CMS_STOP);
		chk({outputs_substitute, program_run}, 32'h2);
		cms_prog_model_inst.xfer(1'b0, `CMS_ADDR_CFG, 32'h0, q, e);
		chk(q, 32'h0);
		cms_prog_model_inst.xfer(1'b0, 12'h008, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
	endtask
	// Startup outputs, run, user breakpoint and unhandled error
	task t_run;
		key(2'h1);
		wait_mode(cms_pkg::CMS_STARTUP);
		chk({startup_handler, timed_irq_block, outputs_disabled, timers_run, meters_run}, 32'h0f);
		pulse(7'h02);
		wait_mode(cms_pkg::CMS_RUN);
		chk({program_run, outputs_substitute}, 32'h2);
		pulse(7'h08);
		wait_mode(cms_pkg::CMS_HOLD);
		ctrl(32'h08);
		wait_mode(cms_pkg::CMS_RUN);
		pulse(7'h10);
		wait_mode(cms_pkg::CMS_STOP);
		key(2'h0);
	endtask
	// Startup breakpoints, stop from hold and a failing startup
	task t_hold;
		key(2'h1);
		wait_mode(cms_pkg::CMS_STARTUP);
		pulse(7'h08);
		wait_mode(cms_pkg::CMS_HOLD);
		ctrl(32'h08);
		wait_mode(cms_pkg::CMS_STARTUP);
		pulse(7'h08);
		wait_mode(cms_pkg::CMS_HOLD);
		ctrl(32'h20);
		wait_mode(cms_pkg::CMS_STOP);
		key(2'h0);
		key(2'h1);
		wait_mode(cms_pkg::CMS_STARTUP);
		pulse(7'h01);
		wait_mode(cms_pkg::CMS_STOP);
		key(2'h0);
	endtask
	// Stop beats hold in one cycle; a start function needs a run position
	task t_prio;
		enter_run();
		pulse(7'h0c);
		wait_mode(cms_pkg::CMS_STOP);
		key(2'h0);
		pulse(7'h20);
		ctrl(32'h10);
		repeat (4) @(posedge pclk);
		#1 chk(32'(mode), 32'(cms_pkg::CMS_STOP));
	endtask
	// Memory clear in stop with a card, refused in run
	task t_clear;
		int c;
		key(2'h3);
		repeat (12) @(posedge pclk);
		key(2'h0);
		chk(32'(n_clr != 0), 32'h1);
		chk(32'(n_cp != 0), 32'h1);
		repeat (12) @(posedge pclk);
		enter_run();
		c = n_clr;
		ctrl(32'h04);
		repeat (4) @(posedge pclk);
		chk(n_clr, c);
		key(2'h0);
		wait_mode(cms_pkg::CMS_STOP);
	endtask
	// Power returns for one cycle with the saved loss conditions
	task power_up(input logic stopped, input logic aborted);
		@(posedge pclk) begin
			power_up_event <= 1'b1;
			stopped_at_power_loss <= stopped;
			warm_aborted_at_power_loss <= aborted;
		end
		@(posedge pclk) power_up_event <= 1'b0;
	endtask
	// Restart type by switch, configuration, command and power return
	task t_restart;
		cms_prog_model_inst.xfer(1'b1, `CMS_ADDR_CFG, 32'h2, q, e);
		cms_prog_model_inst.xfer(1'b0, `CMS_ADDR_CFG, 32'h0, q, e);
		chk(q, 32'h2);
		cms_prog_model_inst.set_restart(1'b0);
		key(2'h1);
		wait_mode(cms_pkg::CMS_STARTUP);
		cms_prog_model_inst.xfer(1'b0, `CMS_ADDR_STATUS, 32'h0, q, e);
		chk(q, 32'ha1);
		ctrl(32'h02);
		wait_mode(cms_pkg::CMS_STOP);
		cms_prog_model_inst.xfer(1'b1, `CMS_ADDR_CFG, 32'h0, q, e);
		ctrl(32'h01);
		wait_mode(cms_pkg::CMS_STARTUP);
		chk({30'h0, startup_handler}, 32'h2);
		ctrl(32'h02);
		wait_mode(cms_pkg::CMS_STOP);
		cms_prog_model_inst.xfer(1'b1, `CMS_ADDR_CFG, 32'h3, q, e);
		ctrl(32'h40);
		wait_mode(cms_pkg::CMS_STARTUP);
		chk({30'h0, startup_handler}, 32'h0);
		pulse(7'h02);
		wait_mode(cms_pkg::CMS_RUN);
		ctrl(32'h02);
		wait_mode(cms_pkg::CMS_STOP);
		power_up(1'b1, 1'b0);
		repeat (4) @(posedge pclk);
		#1 chk(32'(mode), 32'(cms_pkg::CMS_STOP));
		power_up(1'b0, 1'b0);
		wait_mode(cms_pkg::CMS_STARTUP);
		chk({30'h0, startup_handler}, 32'h1);
		ctrl(32'h02);
		wait_mode(cms_pkg::CMS_STOP);
		power_up(1'b0, 1'b1);
		wait_mode(cms_pkg::CMS_STARTUP);
		chk({30'h0, startup_handler}, 32'h0);
		ctrl(32'h02);
		wait_mode(cms_pkg::CMS_STOP);
		key(2'h0);
		cms_prog_model_inst.set_restart(1'b1);
	endtask
	// Fault is sticky until a fresh power-on
	task t_fault;
		pulse(7'h40);
		wait_mode(cms_pkg::CMS_DEFECT);
		key(2'h1);
		repeat (4) @(posedge pclk);
		#1 chk(32'(mode), 32'(cms_pkg::CMS_DEFECT));
		key(2'h0);
		@(posedge pclk) presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		wait_mode(cms_pkg::CMS_STOP);
	endtask

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		$display("reset test finished");
		t_run();
		$display("run test finished");
		t_hold();
		$display("hold test finished");
		t_prio();
		$display("priority test finished");
		t_clear();
		$display("clear test finished");
		t_restart();
		$display("restart test finished");
		t_fault();
		$display("fault test finished");
		test_done();
	end
	// Watchdog far beyond the few hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge pclk);
		mismatches++;
		test_done();
	end
endmodule
